// >>> tsd_defines.svh
// Constants for the torque / step-direction / auto-setup mode block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef TSD_DEFINES_SVH
`define TSD_DEFINES_SVH

// Mode-select codes
`define TSD_MODE_CST        8'h0a
`define TSD_MODE_STEP       8'hff
`define TSD_MODE_SETUP      8'hfe

// Status word bit positions
`define TSD_SW_SYNC         8
`define TSD_SW_INDEXED      10
`define TSD_SW_TARGET       12
`define TSD_SW_FOLLOW_ERR   13

// Control word bit that starts a setup run
`define TSD_CW_START        4

// Interpolation time index accepted (-3 as signed byte)
`define TSD_TIME_INDEX_MS   8'hfd

// Time base: 1 ms at 100 MHz
`define TSD_CLK_NS          10
`define TSD_MS_NS           1000000
`define TSD_MS_CYCLES       (`TSD_MS_NS / `TSD_CLK_NS)

// Step scaling defaults and full-step figures
`define TSD_SCALE_NUM_DEF   32'h0000_0080
`define TSD_SCALE_DEN_DEF   32'h0000_0001
`define TSD_FULL_STEP       32'h0000_0200
`define TSD_STEPS_PER_PP    4

// Step sub-modes
`define TSD_SUB_PULSE_DIR   8'h00
`define TSD_SUB_CW_CCW      8'h01

// Offset scaling: tenths of a percent over a 1000-per-mille base
`define TSD_PERMILLE        16'sd1000

`endif

// >>> tsd_pkg.sv
// Types used by the mode block for its mode and setup states.
// Assumes tsd_defines.svh for numeric constants.
package tsd_pkg;
	typedef enum logic [1:0] {
		TSD_OFF,
		TSD_CST,
		TSD_STEP,
		TSD_SETUP
	} tsd_mode_t;

	typedef enum logic [1:0] {
		TSD_SU_IDLE,
		TSD_SU_RUN,
		TSD_SU_DONE
	} tsd_setup_t;
endpackage : tsd_pkg

// >>> tsd_step_if.sv
// Carrier between the top module and the step pulse counter.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface tsd_step_if;
	logic        enable;      // Step mode active
	logic        subMode;     // 0 pulse/dir, 1 cw/ccw
	logic        cycleTick;   // Interpolation cycle boundary
	logic signed [31:0] netCount;   // Pulses of last cycle, signed
	logic        countValid;  // One-cycle pulse with netCount

	modport top (
		output enable,
		output subMode,
		output cycleTick,
		input  netCount,
		input  countValid
	);
	modport counter (
		input  enable,
		input  subMode,
		input  cycleTick,
		output netCount,
		output countValid
	);
endinterface : tsd_step_if

// >>> tsd_step_counter.sv
// Counts step pulses over one interpolation cycle.
// Assumes synchronised pin levels on the module's clock.
`timescale 1ns/1ps
`include "tsd_defines.svh"
module tsd_step_counter (
	input  wire logic clock,
	input  wire logic rstN,
	input  wire logic pulseA,
	input  wire logic pulseB,
	input  wire logic dirLevel,
	tsd_step_if.counter bus
);
	logic               pulseAPrev_q;
	logic               pulseBPrev_q;
	logic signed [31:0] acc_q;
	logic signed [31:0] acc_d;
	logic signed [31:0] net_q;
	logic               valid_q;
	logic               riseA;
	logic               riseB;
	logic signed [31:0] delta;

	////////////////////////////////////////////////////////////////////////
	// Edge detect and direction per sub-mode
	assign riseA = pulseA & ~pulseAPrev_q;
	assign riseB = pulseB & ~pulseBPrev_q;
	assign delta = (!bus.subMode) ?
		(riseA ? (dirLevel ? -32'sd1 : 32'sd1) : 32'sd0) :
		((riseA ? 32'sd1 : 32'sd0) - (riseB ? 32'sd1 : 32'sd0));
	// Restart collection at each boundary, drop all when mode left
	assign acc_d = !bus.enable ? 32'sd0 :
		(bus.cycleTick ? delta : acc_q + delta);

	////////////////////////////////////////////////////////////////////////
	// Pulse accumulator
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			pulseAPrev_q <= 1'b0;
			pulseBPrev_q <= 1'b0;
			acc_q        <= 32'sd0;
			net_q        <= 32'sd0;
			valid_q      <= 1'b0;
		end else begin
			pulseAPrev_q <= pulseA;
			pulseBPrev_q <= pulseB;
			acc_q        <= acc_d;
			net_q        <= bus.cycleTick ? acc_q : net_q;
			valid_q      <= bus.cycleTick & bus.enable;
		end
	end

	assign bus.netCount   = net_q;
	assign bus.countValid = valid_q;
endmodule : tsd_step_counter

// >>> tsd_follow_monitor.sv
// Following-error monitor: corridor plus millisecond timeout.
// Assumes a one-cycle millisecond tick on the same clock.
`timescale 1ns/1ps
module tsd_follow_monitor (
	input  wire logic               clock,
	input  wire logic               rstN,
	input  wire logic               enable,
	input  wire logic               msTick,
	input  wire logic signed [31:0] demandPos,
	input  wire logic signed [31:0] actualPos,
	input  wire logic        [31:0] window,
	input  wire logic        [15:0] timeoutMs,
	output logic                    followErr
);
	logic signed [31:0] diff;
	logic        [31:0] mag;
	logic               outside;
	logic        [15:0] msCnt_q;
	logic               err_q;

	// Distance from demand to actual position
	assign diff    = demandPos - actualPos;
	assign mag     = diff[31] ? 32'(-diff) : 32'(diff);
	assign outside = enable && (mag > window);

	////////////////////////////////////////////////////////////////////////
	// Time spent outside the corridor
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			msCnt_q <= 16'h0000;
			err_q   <= 1'b0;
		end else if (!outside) begin
			msCnt_q <= 16'h0000;
			err_q   <= 1'b0;
		end else if (msTick && msCnt_q != 16'hffff) begin
			msCnt_q <= msCnt_q + 16'h0001;
			err_q   <= (msCnt_q >= timeoutMs);
		end
	end

	assign followErr = err_q;
endmodule : tsd_follow_monitor

// >>> tsd_mode_drive.sv
// Operating-mode logic: cyclic torque, step/direction, auto setup.
// Assumes pins asynchronous to clock; setup engine is external.
//
// Overview of operation
// - Mode code 10 selects cyclic torque
// - Control word has no meaning in torque
// - Status bit 8 shows cycle sync
// - Status bit 12 shows torque followed
// - Torque preset followed directly, no ramp
// - Clamp to min of torque, current ceilings
// - Cycle is period times ten^index, index -3
// - Add torque offset in tenths percent
// - Mode code -1 selects step mode
// - Each pulse moves one scaled step
// - Pulses buffered, applied once per cycle
// - Step scaled by numerator over denominator
// - Four full steps per pole pair
// - Status bit 13 flags following error
// - Sub-mode 0: clock input plus direction
// - Sub-mode 1: input chosen gives direction
// - Mode code -2 selects auto setup
// - Setup starts on control bit 4 rise
// - Bit 10 indexed, bit 12 setup done
// - Following error after corridor timeout
`timescale 1ns/1ps
`include "tsd_defines.svh"
module tsd_mode_drive (
	input  wire logic               clock,
	input  wire logic               arst_n,
	input  wire logic        [7:0]  operatingModeSelect,
	input  wire logic        [15:0] driveControlWord,
	input  wire logic signed [15:0] torqueSetpoint,
	input  wire logic               torqueSetpointWr,
	input  wire logic        [15:0] torqueCeiling,
	input  wire logic        [15:0] currentCeiling,
	input  wire logic        [7:0]  interpolationPeriod,
	input  wire logic        [7:0]  interpolationIndex,
	input  wire logic signed [15:0] torqueSetpointOffset,
	input  wire logic        [31:0] stepScaleNumerator,
	input  wire logic        [31:0] stepScaleDenominator,
	input  wire logic        [7:0]  stepSubmodeSelect,
	input  wire logic        [31:0] trackingErrorWindow,
	input  wire logic        [15:0] trackingErrorTimeout,
	input  wire logic               closedLoopEnable,
	input  wire logic signed [31:0] actualPosition,
	input  wire logic               stepClockPin,
	input  wire logic               stepDirPin,
	input  wire logic               encoderIndexFound,
	input  wire logic               setupFinished,
	output logic             [15:0] driveStatusWord,
	output logic signed      [15:0] torqueDemand,
	output logic signed      [31:0] demandPosition,
	output logic                    setupStart,
	output logic                    cycleSync
);
	logic               rstMeta_q;
	logic               rstN;
	logic               clkMeta_q;
	logic               clkSync_q;
	logic               dirMeta_q;
	logic               dirSync_q;
	logic [16:0]        msCnt_q;
	logic               msTick;
	logic [7:0]         cycCnt_q;
	logic               cycleTick;
	logic               indexOk;
	logic               wrSeen_q;
	logic               sync_q;
	logic signed [15:0] preset_q;
	logic signed [31:0] scaledOffset;
	logic signed [31:0] rawTorque;
	logic        [15:0] limit;
	logic signed [31:0] clamped;
	logic signed [15:0] torque_q;
	logic signed [31:0] pos_q;
	logic signed [63:0] stepProduct;
	logic signed [31:0] stepDelta;
	logic               startPrev_q;
	logic               startRise;
	logic               setupStart_q;
	logic [15:0]        status_q;
	logic [15:0]        status_d;
	logic               followErr;
	logic               stepPulseA;
	logic               stepPulseB;
	tsd_pkg::tsd_mode_t  mode;
	tsd_pkg::tsd_setup_t setup_q;
	tsd_pkg::tsd_setup_t setup_d;
	tsd_step_if          stepBus ();

	// Mode code decoding, shared by mode and status logic
	function automatic tsd_pkg::tsd_mode_t decodeMode(input logic [7:0] c);
		if (c == `TSD_MODE_CST)
			return tsd_pkg::TSD_CST;
		else if (c == `TSD_MODE_STEP)
			return tsd_pkg::TSD_STEP;
		else if (c == `TSD_MODE_SETUP)
			return tsd_pkg::TSD_SETUP;
		else
			return tsd_pkg::TSD_OFF;
	endfunction : decodeMode

	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_q <= 1'b0;
			rstN      <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstN      <= rstMeta_q;
		end
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			clkMeta_q <= 1'b0;
			clkSync_q <= 1'b0;
			dirMeta_q <= 1'b0;
			dirSync_q <= 1'b0;
		end else begin
			clkMeta_q <= stepClockPin;
			clkSync_q <= clkMeta_q;
			dirMeta_q <= stepDirPin;
			dirSync_q <= dirMeta_q;
		end
	end

	assign mode = decodeMode(operatingModeSelect);

	////////////////////////////////////////////////////////////////////////
	// Millisecond base and interpolation cycle
	assign msTick    = (msCnt_q == 17'(`TSD_MS_CYCLES - 1));
	assign indexOk   = (interpolationIndex == `TSD_TIME_INDEX_MS);
	assign cycleTick = msTick && indexOk &&
		(cycCnt_q + 8'h01 >= interpolationPeriod);

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			msCnt_q  <= 17'h00000;
			cycCnt_q <= 8'h00;
		end else begin
			msCnt_q  <= msTick ? 17'h00000 : msCnt_q + 17'h00001;
			cycCnt_q <= cycleTick ? 8'h00 :
				(msTick ? cycCnt_q + 8'h01 : cycCnt_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Torque path: hold preset, add offset, clamp
	// Signed product keeps a negative offset negative
	assign scaledOffset = (32'(torqueSetpointOffset) *
		$signed({16'h0000, torqueCeiling})) /
		32'(`TSD_PERMILLE);
	assign rawTorque = 32'(preset_q) + scaledOffset;
	assign limit     = (torqueCeiling < currentCeiling) ?
		torqueCeiling : currentCeiling;
	assign clamped   = (rawTorque > $signed({16'h0000, limit})) ?
		$signed({16'h0000, limit}) :
		((rawTorque < -$signed({16'h0000, limit})) ?
		-$signed({16'h0000, limit}) : rawTorque);

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			preset_q <= 16'sh0000;
			torque_q <= 16'sh0000;
			wrSeen_q <= 1'b0;
			sync_q   <= 1'b0;
		end else begin
			// Latest preset is kept until the next write
			if (torqueSetpointWr)
				preset_q <= torqueSetpoint;
			torque_q <= (mode == tsd_pkg::TSD_CST) ?
				clamped[15:0] : 16'sh0000;
			// Sync: a write seen in each completed cycle
			if (mode != tsd_pkg::TSD_CST || !indexOk) begin
				wrSeen_q <= 1'b0;
				sync_q   <= 1'b0;
			end else if (cycleTick) begin
				sync_q   <= wrSeen_q | torqueSetpointWr;
				wrSeen_q <= 1'b0;
			end else if (torqueSetpointWr) begin
				wrSeen_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Step mode: pulses counted per cycle, then scaled into position
	assign stepPulseA = (stepSubmodeSelect == `TSD_SUB_PULSE_DIR) ?
		clkSync_q : clkSync_q;
	assign stepPulseB = (stepSubmodeSelect == `TSD_SUB_CW_CCW) ?
		dirSync_q : 1'b0;
	assign stepBus.enable    = (mode == tsd_pkg::TSD_STEP);
	assign stepBus.subMode   = (stepSubmodeSelect == `TSD_SUB_CW_CCW);
	assign stepBus.cycleTick = cycleTick;

	tsd_step_counter u_counter (
		.clock    (clock),
		.rstN     (rstN),
		.pulseA   (stepPulseA),
		.pulseB   (stepPulseB),
		.dirLevel (dirSync_q),
		.bus      (stepBus.counter)
	);

	// Scaled step width; units of 1/512 full step keep the motor
	// treated as a stepper, four full steps per pole pair
	assign stepProduct = 64'(stepBus.netCount) *
		64'($signed({1'b0, stepScaleNumerator[30:0]}));
	assign stepDelta = (stepScaleDenominator == 32'h0000_0000) ?
		32'sd0 : 32'(stepProduct /
		64'($signed({1'b0, stepScaleDenominator[30:0]})));

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN)
			pos_q <= 32'sd0;
		else if (stepBus.countValid && mode == tsd_pkg::TSD_STEP)
			pos_q <= pos_q + stepDelta;
	end

	tsd_follow_monitor u_follow (
		.clock     (clock),
		.rstN      (rstN),
		.enable    (closedLoopEnable && mode == tsd_pkg::TSD_STEP),
		.msTick    (msTick),
		.demandPos (pos_q),
		.actualPos (actualPosition),
		.window    (trackingErrorWindow),
		.timeoutMs (trackingErrorTimeout),
		.followErr (followErr)
	);

	////////////////////////////////////////////////////////////////////////
	// Auto setup sequencing
	assign startRise = driveControlWord[`TSD_CW_START] & ~startPrev_q;

	always_comb begin
		setup_d = setup_q;
		case (setup_q)
			tsd_pkg::TSD_SU_IDLE: begin
				if (mode == tsd_pkg::TSD_SETUP && startRise)
					setup_d = tsd_pkg::TSD_SU_RUN;
			end
			tsd_pkg::TSD_SU_RUN: begin
				if (mode != tsd_pkg::TSD_SETUP)
					setup_d = tsd_pkg::TSD_SU_IDLE;
				else if (setupFinished)
					setup_d = tsd_pkg::TSD_SU_DONE;
			end
			tsd_pkg::TSD_SU_DONE: begin
				if (mode != tsd_pkg::TSD_SETUP)
					setup_d = tsd_pkg::TSD_SU_IDLE;
				else if (startRise)
					setup_d = tsd_pkg::TSD_SU_RUN;
			end
			default: setup_d = tsd_pkg::TSD_SU_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			setup_q      <= tsd_pkg::TSD_SU_IDLE;
			startPrev_q  <= 1'b0;
			setupStart_q <= 1'b0;
		end else begin
			setup_q      <= setup_d;
			startPrev_q  <= driveControlWord[`TSD_CW_START];
			setupStart_q <= (setup_d == tsd_pkg::TSD_SU_RUN) &&
				(setup_q != tsd_pkg::TSD_SU_RUN);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status word; in torque mode the control word is not consulted
	always_comb begin
		status_d = 16'h0000;
		case (mode)
			tsd_pkg::TSD_CST: begin
				status_d[`TSD_SW_SYNC]   = sync_q;
				status_d[`TSD_SW_TARGET] = sync_q;
			end
			tsd_pkg::TSD_STEP: begin
				status_d[`TSD_SW_FOLLOW_ERR] = followErr;
			end
			tsd_pkg::TSD_SETUP: begin
				status_d[`TSD_SW_INDEXED] = encoderIndexFound;
				status_d[`TSD_SW_TARGET]  =
					(setup_q == tsd_pkg::TSD_SU_DONE);
			end
			default: status_d = 16'h0000;
		endcase
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN)
			status_q <= 16'h0000;
		else
			status_q <= status_d;
	end

	assign driveStatusWord = status_q;
	assign torqueDemand    = torque_q;
	assign demandPosition  = pos_q;
	assign setupStart      = setupStart_q;
	assign cycleSync       = sync_q;
endmodule : tsd_mode_drive

// >>> tsd_step_source.sv
// Step source model standing in for the positioning controller.
// Assumes the bench clock at 100 MHz; pins change at falling edges.
`timescale 1ns/1ps
module tsd_step_source (
	input  wire logic clock,
	output logic      clkPin,
	output logic      dirPin
);
	// Pins idle low until a pulse or a direction change
	initial begin
		clkPin = 1'b0;
		dirPin = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// 200 ns high within a 1.01 us period on the clock or direction pin
	task automatic pulses(input logic onDir, input int cnt);
		repeat (cnt) begin
			@(negedge clock);
			clkPin = ~onDir;
			dirPin = dirPin | onDir;
			repeat (8'h14) @(negedge clock);
			clkPin = 1'b0;
			dirPin = dirPin & ~onDir;
			repeat (8'h50) @(negedge clock);
		end
	endtask : pulses

	// New level, then 35 us of quiet before any pulse
	task automatic setDir(input logic lvl);
		@(negedge clock);
		dirPin = lvl;
		repeat (16'hdac) @(negedge clock);
	endtask : setDir
endmodule : tsd_step_source

// >>> tsd_mode_drive_asserts.sv
// Concurrent checks on the ports of the operating-mode block.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module tsd_mode_drive_asserts (
	input wire logic               clock,
	input wire logic               arst_n,
	input wire logic        [7:0]  operatingModeSelect,
	input wire logic        [15:0] driveControlWord,
	input wire logic signed [15:0] torqueSetpoint,
	input wire logic               torqueSetpointWr,
	input wire logic        [15:0] torqueCeiling,
	input wire logic        [15:0] currentCeiling,
	input wire logic signed [15:0] torqueSetpointOffset,
	input wire logic               setupFinished,
	input wire logic        [15:0] driveStatusWord,
	input wire logic signed [15:0] torqueDemand,
	input wire logic signed [31:0] demandPosition,
	input wire logic               setupStart
);
	logic signed [16:0] lim;
	logic        [16:0] sinceChg_q;

	// Smaller of the two ceilings
	assign lim = (torqueCeiling < currentCeiling) ? {1'b0, torqueCeiling}
		: {1'b0, currentCeiling};

	// Cycles since the demand position last moved, saturating
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			sinceChg_q <= '1;
		else if ($changed(demandPosition))
			sinceChg_q <= '0;
		else if (~&sinceChg_q)
			sinceChg_q <= sinceChg_q + 17'h1;
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	chk_torque_clamp: assert property (
		torqueDemand <= lim && torqueDemand >= -lim)
		else $error("torque demand beyond ceiling");
	chk_torque_follow: assert property (
		torqueSetpointWr && operatingModeSelect == 8'h0a
		&& torqueSetpointOffset == 16'sh0 && torqueSetpoint <= lim
		&& torqueSetpoint >= -lim ##1 operatingModeSelect == 8'h0a
		|=> torqueDemand == $past(torqueSetpoint, 2))
		else $error("torque demand not the written preset");
	chk_torque_hold: assert property (
		!$past(torqueSetpointWr) && !$past(torqueSetpointWr, 2)
		&& $past(operatingModeSelect) == 8'h0a
		&& $past(operatingModeSelect, 2) == 8'h0a |-> $stable(torqueDemand))
		else $error("torque demand moved without a write");
	chk_setup_start: assert property (
		operatingModeSelect == 8'hfe && $past(operatingModeSelect) == 8'hfe
		&& $rose(driveControlWord[4]) |=> setupStart)
		else $error("no setup start after control rise");
	chk_setup_cause: assert property (
		setupStart |-> $past(operatingModeSelect) == 8'hfe
		&& $past(driveControlWord[4]) && !$past(driveControlWord[4], 2))
		else $error("setup start without mode and rise");
	chk_setup_done: assert property (
		operatingModeSelect == 8'hfe && setupFinished
		##1 operatingModeSelect == 8'hfe |=> driveStatusWord[12])
		else $error("aligned bit missing after setup end");
	chk_step_once: assert property (
		$changed(demandPosition) |-> sinceChg_q >= 17'h18696)
		else $error("demand position moved twice in a cycle");
	chk_follow_mode: assert property (
		$past(operatingModeSelect) != 8'hff
		&& $past(operatingModeSelect, 2) != 8'hff |-> !driveStatusWord[13])
		else $error("following error outside step mode");
endmodule : tsd_mode_drive_asserts

bind tsd_mode_drive tsd_mode_drive_asserts tsd_mode_drive_asserts_inst (.*);

// >>> tb.sv
// Self-checking bench for the operating-mode block.
// Assumes the bound checker and the step source model are compiled.
`timescale 1ns/1ps
module tb;
	logic               clock, arst_n, torqueSetpointWr, closedLoopEnable;
	logic               encoderIndexFound, setupFinished, stepClockPin;
	logic               stepDirPin, setupStart, cycleSync;
	logic        [7:0]  operatingModeSelect, interpolationPeriod;
	logic        [7:0]  interpolationIndex, stepSubmodeSelect;
	logic        [15:0] driveControlWord, torqueCeiling, currentCeiling;
	logic        [15:0] trackingErrorTimeout, driveStatusWord;
	logic        [31:0] stepScaleNumerator, stepScaleDenominator;
	logic        [31:0] trackingErrorWindow;
	logic signed [15:0] torqueSetpoint, torqueSetpointOffset, torqueDemand;
	logic signed [31:0] actualPosition, demandPosition, p0;
	int                 error_cnt, num_checks, n;

	tsd_mode_drive tsd_mode_drive_inst (.*);
	tsd_step_source tsd_step_source_inst (
		.clock  (clock),
		.clkPin (stepClockPin),
		.dirPin (stepDirPin)
	);

	// Free-running 100 MHz clock
	always #5 clock = ~clock;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s: got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	task automatic tmo(input logic ok, input string m);
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t wait ran out: %s", $time, m);
			end_of_test();
		end
	endtask : tmo

	task automatic cyc(input int k);
		repeat (k) @(negedge clock);
	endtask : cyc

	// Preset write, then the demand two cycles on
	task automatic put(input logic signed [15:0] v, input int e);
		cyc(1);
		torqueSetpointWr = 1'b1;
		torqueSetpoint = v;
		cyc(1);
		torqueSetpointWr = 1'b0;
		cyc(2);
		chk(torqueDemand, e, "torque demand");
	endtask : put

	// Wait for the next position update and compare it
	task automatic waitPos(input logic signed [31:0] e);
		for (n = 0; n < 32'h1adb0 && demandPosition === p0; n++)
			cyc(1);
		tmo(demandPosition !== p0, "position update");
		cyc(3);
		chk(demandPosition, e, "demand position");
	endtask : waitPos

	////////////////////////////////////////////////////////////////////////
	task automatic testTorque();
		operatingModeSelect = 8'h0a;
		cyc(3);
		put(16'sh00c8, 32'sh00c8);
		operatingModeSelect = 8'h00;
		torqueSetpointOffset = 16'sh0064;
		cyc(3);
		chk(torqueDemand, 32'h0, "outside torque mode");
		operatingModeSelect = 8'h0a;
		torqueSetpointWr = 1'b1;
		torqueSetpoint = -16'sh0032;
		put(16'sh0226, 32'sh0258);
		put(-16'sh0320, -32'sh0258);
		put(16'sh00c8, 32'sh012c);
		driveControlWord = 16'hffff;
		cyc(20);
		chk(torqueDemand, 32'sh012c, "held preset");
		chk(setupStart, 1'b0, "control bits ignored");
		operatingModeSelect = 8'h00;
		torqueSetpointOffset = -16'sh0064;
		cyc(2);
		operatingModeSelect = 8'h0a;
		put(16'sh00c8, 32'sh0064);
		$display("torque test done");
	endtask : testTorque

	task automatic testSync();
		for (n = 0; n < 32'h1d4c0 && cycleSync !== 1'b1; n++) begin
			torqueSetpointWr = (n % 32'h64 == 32'h32);
			cyc(1);
		end
		torqueSetpointWr = 1'b0;
		tmo(cycleSync === 1'b1, "sync rise");
		cyc(2);
		chk(driveStatusWord[8], 1'b1, "in sync");
		chk(driveStatusWord[12], 1'b1, "target used");
		for (n = 2; n < 32'h1adb0 && cycleSync === 1'b1; n++)
			cyc(1);
		tmo(cycleSync === 1'b0, "sync fall");
		chk(n, 32'h186a0, "cycle length");
		cyc(2);
		chk(driveStatusWord[8], 1'b0, "out of sync");
		chk(driveStatusWord[12], 1'b0, "target ignored");
		$display("sync test done");
	endtask : testSync

	task automatic testStep();
		operatingModeSelect = 8'hff;
		cyc(5);
		p0 = demandPosition;
		tsd_step_source_inst.pulses(1'b0, 5);
		tsd_step_source_inst.setDir(1'b1);
		tsd_step_source_inst.pulses(1'b0, 2);
		tsd_step_source_inst.setDir(1'b0);
		waitPos(p0 + 32'sh180);
		stepSubmodeSelect = 8'h01;
		stepScaleNumerator = 32'h200;
		stepScaleDenominator = 32'h2;
		p0 = demandPosition;
		tsd_step_source_inst.pulses(1'b0, 3);
		operatingModeSelect = 8'h00;
		cyc(5);
		operatingModeSelect = 8'hff;
		cyc(5);
		tsd_step_source_inst.pulses(1'b0, 1);
		tsd_step_source_inst.pulses(1'b1, 3);
		waitPos(p0 - 32'sh200);
		$display("step test done");
	endtask : testStep

	task automatic testFollow();
		trackingErrorWindow = 32'ha;
		actualPosition = 32'sh0;
		closedLoopEnable = 1'b1;
		for (n = 0; n < 32'h33450 && driveStatusWord[13] !== 1'b1; n++)
			cyc(1);
		tmo(driveStatusWord[13] === 1'b1, "following error");
		actualPosition = demandPosition;
		cyc(3);
		chk(driveStatusWord[13], 1'b0, "back in corridor");
		closedLoopEnable = 1'b0;
		$display("following error test done");
	endtask : testFollow

	task automatic testSetup();
		operatingModeSelect = 8'hfe;
		cyc(5);
		chk(setupStart, 1'b0, "level is no start");
		driveControlWord = 16'h0000;
		cyc(2);
		driveControlWord = 16'h0010;
		cyc(1);
		chk(setupStart, 1'b1, "setup start");
		chk(driveStatusWord[12], 1'b0, "run not done");
		encoderIndexFound = 1'b1;
		setupFinished = 1'b1;
		cyc(1);
		setupFinished = 1'b0;
		cyc(3);
		chk(driveStatusWord[10], 1'b1, "index found");
		chk(driveStatusWord[12], 1'b1, "aligned");
		$display("setup test done");
	endtask : testSetup

	////////////////////////////////////////////////////////////////////////
	// Inputs settled at time zero, reset held for three cycles
	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		operatingModeSelect = 8'h00;
		driveControlWord = 16'h0000;
		torqueSetpoint = 16'sh0000;
		torqueSetpointWr = 1'b0;
		torqueCeiling = 16'h03e8;
		currentCeiling = 16'h0258;
		interpolationPeriod = 8'h01;
		interpolationIndex = 8'hfd;
		torqueSetpointOffset = 16'sh0000;
		stepScaleNumerator = 32'h80;
		stepScaleDenominator = 32'h1;
		stepSubmodeSelect = 8'h00;
		trackingErrorWindow = 32'h7fffffff;
		trackingErrorTimeout = 16'h0000;
		closedLoopEnable = 1'b0;
		actualPosition = 32'sh0;
		encoderIndexFound = 1'b0;
		setupFinished = 1'b0;
		cyc(3);
		arst_n = 1'b1;
		cyc(4);
		testTorque();
		testSync();
		testStep();
		testFollow();
		testSetup();
		end_of_test();
	end
endmodule : tb
